// ===== fpma_pkg.sv
// Package of constants, register map and state types for the panel block
package fpma_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ        = 10_000_000;
  localparam int HOLD_TIME_MS  = 5000;  // Long press for mode entry / exit
  localparam int DEBOUNCE_MS   = 20;    // Button settle time
  localparam int FLASH_MS      = 250;   // Half period of LED flashing
  localparam int HOLD_CYC      = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC     = FLASH_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Register map (byte offsets)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ALARM_EN  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_SETTING   = 8'h14;
  localparam logic [7:0] OFS_IP_ADDR   = 8'h18;
  localparam logic [7:0] OFS_NET_MASK  = 8'h1C;
  localparam logic [7:0] OFS_GATEWAY   = 8'h20;
  localparam logic [7:0] OFS_ADDR_METH = 8'h24;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int NUM_ERR  = 8;          // Error conditions, bit 0 = supply
  localparam int NUM_IRQ  = 4;
  localparam int BIT_SUP_EN = 0;        // CTRL: redundancy supervision
  localparam int ERR_SUPPLY = 0;
  localparam int ERR_POE    = 1;
  localparam int IRQ_SUP    = 0;        // Supply error became active
  localparam int IRQ_ENTER  = 1;        // Selection mode entered
  localparam int IRQ_COMMIT = 2;        // Selection committed
  localparam int IRQ_ALARM  = 3;        // Alarm contact opened
  localparam logic           RST_SUP_EN   = 1'b1;
  localparam logic [NUM_ERR-1:0] RST_ALARM_EN = 8'h03;
  localparam logic [NUM_IRQ-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [31:0]    RST_IP       = 32'h00000000;
  localparam logic [1:0]     METH_BOOTP   = 2'h0;
  localparam logic [1:0]     METH_STATIC  = 2'h1;

  // Operating modes and pending selections
  localparam logic [1:0] OPM_PLAIN  = 2'h0;
  localparam logic [1:0] OPM_PROT_A = 2'h1;
  localparam logic [1:0] OPM_PROT_B = 2'h2;
  localparam logic [1:0] SEL_KEEP    = 2'h0;
  localparam logic [1:0] SEL_DEFAULT = 2'h1;
  localparam logic [1:0] SEL_PROT_A  = 2'h2;
  localparam logic [1:0] SEL_PROT_B  = 2'h3;

  // LED patterns, bit 0 = LED 1
  localparam logic [2:0] LED_KEEP    = 3'h4;
  localparam logic [2:0] LED_DEFAULT = 3'h2;
  localparam logic [2:0] LED_PROT_A  = 3'h6;
  localparam logic [2:0] LED_PROT_B  = 3'h1;
  localparam logic [2:0] LED_ALL     = 3'h7;
  localparam logic [2:0] LED_DARK    = 3'h0;
  localparam logic [2:0] DISP_BLANK  = 3'h0;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ENTER_REL,
    ST_SELECT,
    ST_EXIT_REL
  } fpma_mode_t;

  typedef struct packed {
    fpma_mode_t         mode;
    logic               sup_en;
    logic [NUM_ERR-1:0] alarm_en;
    logic [NUM_IRQ-1:0] irq_stat;
    logic [NUM_IRQ-1:0] irq_mask;
    logic [31:0]        ip_addr;
    logic [31:0]        net_mask;
    logic [31:0]        gateway;
    logic [1:0]         addr_meth;
    logic [1:0]         op_mode;
    logic [1:0]         sel;
    logic [31:0]        db_cnt;
    logic               btn_db;
    logic               btn_prev;
    logic [31:0]        hold_cnt;
    logic [31:0]        flash_cnt;
    logic               flash_ph;
    logic [2:0]         led;
    logic [2:0]         disp;
    logic               alarm_closed;
    logic               sup_err_prev;
    logic               irq;
    logic               save_req;
    logic               commit;
    logic [31:0]        rdata;
  } fpma_state_t;

  // LED pattern of a pending selection
  function automatic logic [2:0] sel_leds(input logic [1:0] s);
    case (s)
      SEL_KEEP:    sel_leds = LED_KEEP;
      SEL_DEFAULT: sel_leds = LED_DEFAULT;
      SEL_PROT_A:  sel_leds = LED_PROT_A;
      default:     sel_leds = LED_PROT_B;
    endcase
  endfunction : sel_leds

endpackage : fpma_pkg

// ===== fpma_top.sv
// Front panel supervision: supply redundancy, alarm contact, selection mode
//
// The register offsets and the address-and-strobe port were chosen for this implementation.

module fpma_top #(
  parameter int HOLD_CYCLES     = fpma_pkg::HOLD_CYC,
  parameter int DEBOUNCE_CYCLES = fpma_pkg::DEBOUNCE_CYC,
  parameter int FLASH_CYCLES    = fpma_pkg::FLASH_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Supplies and error sources
  input  wire logic        supply_input_a,
  input  wire logic        supply_input_b,
  input  wire logic [fpma_pkg::NUM_ERR-1:1] ext_fault,
  // System events
  input  wire logic        boot_done,
  input  wire logic        restart_req,
  input  wire logic        mem_present,
  // Panel
  input  wire logic        mode_button,
  output logic      [2:0]  mode_led,
  output logic      [2:0]  disp_code,
  output logic             alarm_closed,
  // Configuration outputs
  output logic      [1:0]  op_mode,
  output logic             cfg_commit,
  output logic             cfg_save_req,
  output logic             irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  fpma_pkg::fpma_state_t st_reg;
  fpma_pkg::fpma_state_t st_next;

  logic                         sup_err;
  logic [fpma_pkg::NUM_ERR-1:0] err_vec;
  logic [fpma_pkg::NUM_ERR-1:0] err_on;
  logic                         hold_hit;
  logic                         released;
  logic                         rd_hit_irq;
  logic [fpma_pkg::NUM_IRQ-1:0] irq_set;

  // Error conditions and their alarm gating
  always_comb begin
    sup_err = st_reg.sup_en & (supply_input_a ^ supply_input_b);
    err_vec = {ext_fault, sup_err};
    err_on  = err_vec & st_reg.alarm_en;
  end

  // Button events from the debounced level
  always_comb begin
    hold_hit = st_reg.btn_db && boot_done &&
               (st_reg.hold_cnt == 32'(HOLD_CYCLES - 1));
    released = st_reg.btn_prev && !st_reg.btn_db;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next    = st_reg;
    irq_set    = '0;
    rd_hit_irq = reg_rd && (reg_addr == fpma_pkg::OFS_IRQ_STAT);
    st_next.commit   = 1'b0;
    st_next.save_req = 1'b0;

    // Debounce: the level must differ for the full settle time
    if (mode_button != st_reg.btn_db) begin
      if (st_reg.db_cnt >= 32'(DEBOUNCE_CYCLES - 1)) begin
        st_next.btn_db = mode_button;
        st_next.db_cnt = '0;
      end else begin
        st_next.db_cnt = st_reg.db_cnt + 32'h00000001;
      end
    end else begin
      st_next.db_cnt = '0;
    end
    st_next.btn_prev = st_reg.btn_db;

    // Hold timer runs only on the debounced, pressed level
    if (st_reg.btn_db && boot_done) begin
      if (st_reg.hold_cnt != 32'(HOLD_CYCLES - 1)) begin
        st_next.hold_cnt = st_reg.hold_cnt + 32'h00000001;
      end
    end else begin
      st_next.hold_cnt = '0;
    end

    // Selection mode sequencing
    case (st_reg.mode)
      fpma_pkg::ST_IDLE: begin
        if (hold_hit) begin
          st_next.mode = fpma_pkg::ST_ENTER_REL;
          st_next.sel  = fpma_pkg::SEL_KEEP;
          irq_set[fpma_pkg::IRQ_ENTER] = 1'b1;
        end
      end
      fpma_pkg::ST_ENTER_REL: begin
        if (!st_reg.btn_db) begin
          st_next.mode = fpma_pkg::ST_SELECT;
        end
      end
      fpma_pkg::ST_SELECT: begin
        if (hold_hit) begin
          st_next.mode   = fpma_pkg::ST_EXIT_REL;
          st_next.commit = 1'b1;
          irq_set[fpma_pkg::IRQ_COMMIT] = 1'b1;
          case (st_reg.sel)
            fpma_pkg::SEL_DEFAULT: begin
              st_next.ip_addr   = fpma_pkg::RST_IP;
              st_next.net_mask  = fpma_pkg::RST_IP;
              st_next.gateway   = fpma_pkg::RST_IP;
              st_next.addr_meth = fpma_pkg::METH_BOOTP;
              st_next.op_mode   = fpma_pkg::OPM_PLAIN;
            end
            fpma_pkg::SEL_PROT_A: st_next.op_mode = fpma_pkg::OPM_PROT_A;
            fpma_pkg::SEL_PROT_B: st_next.op_mode = fpma_pkg::OPM_PROT_B;
            default: st_next.op_mode = st_reg.op_mode;
          endcase
        end else if (released) begin
          st_next.sel = st_reg.sel + 2'h1;
        end
      end
      fpma_pkg::ST_EXIT_REL: begin
        if (!st_reg.btn_db) begin
          st_next.mode = fpma_pkg::ST_IDLE;
        end
      end
      default: st_next.mode = fpma_pkg::ST_IDLE;
    endcase

    // Flash timebase, restarted whenever the mode is idle
    if (st_reg.mode == fpma_pkg::ST_IDLE) begin
      st_next.flash_cnt = '0;
      st_next.flash_ph  = 1'b0;
    end else if (st_reg.flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
      st_next.flash_cnt = '0;
      st_next.flash_ph  = !st_reg.flash_ph;
    end else begin
      st_next.flash_cnt = st_reg.flash_cnt + 32'h00000001;
    end

    // LEDs alternate all-on and pending pattern; dark once committed
    if (st_next.mode == fpma_pkg::ST_IDLE ||
        st_next.mode == fpma_pkg::ST_EXIT_REL) begin
      st_next.led  = fpma_pkg::LED_DARK;
      st_next.disp = fpma_pkg::DISP_BLANK;
    end else begin
      st_next.led  = st_next.flash_ph ? fpma_pkg::sel_leds(st_next.sel)
                                      : fpma_pkg::LED_ALL;
      st_next.disp = {1'b0, st_next.sel} + 3'h1;
    end

    // Alarm contact closed only while no enabled error is present
    st_next.alarm_closed = ~|err_on;
    st_next.sup_err_prev = sup_err;
    if (sup_err && !st_reg.sup_err_prev) begin
      irq_set[fpma_pkg::IRQ_SUP] = 1'b1;
    end
    if (|err_on && st_reg.alarm_closed) begin
      irq_set[fpma_pkg::IRQ_ALARM] = 1'b1;
    end

    // Restart stores the active configuration when a module is fitted
    st_next.save_req = restart_req && mem_present;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        fpma_pkg::OFS_CTRL:
          st_next.sup_en = reg_wdata[fpma_pkg::BIT_SUP_EN];
        fpma_pkg::OFS_ALARM_EN:
          st_next.alarm_en = reg_wdata[fpma_pkg::NUM_ERR-1:0];
        fpma_pkg::OFS_IRQ_MASK:
          st_next.irq_mask = reg_wdata[fpma_pkg::NUM_IRQ-1:0];
        fpma_pkg::OFS_SETTING:
          st_next.op_mode = reg_wdata[1:0];
        fpma_pkg::OFS_IP_ADDR:   st_next.ip_addr   = reg_wdata;
        fpma_pkg::OFS_NET_MASK:  st_next.net_mask  = reg_wdata;
        fpma_pkg::OFS_GATEWAY:   st_next.gateway   = reg_wdata;
        fpma_pkg::OFS_ADDR_METH: st_next.addr_meth = reg_wdata[1:0];
        default: st_next.sup_en = st_reg.sup_en;
      endcase
    end

    // Sticky status: read clears, a new event in the same cycle wins
    st_next.irq_stat = (rd_hit_irq ? '0 : st_reg.irq_stat) | irq_set;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

    // Register reads, data valid in the following cycle only
    st_next.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        fpma_pkg::OFS_CTRL:
          st_next.rdata = {31'h00000000, st_reg.sup_en};
        fpma_pkg::OFS_ALARM_EN:
          st_next.rdata = {24'h000000, st_reg.alarm_en};
        fpma_pkg::OFS_STATUS:
          st_next.rdata = {16'h0000, supply_input_b, supply_input_a,
                           st_reg.op_mode,
                           (st_reg.mode != fpma_pkg::ST_IDLE),
                           st_reg.sel, st_reg.alarm_closed, err_vec};
        fpma_pkg::OFS_IRQ_STAT:
          st_next.rdata = {28'h0000000, st_reg.irq_stat};
        fpma_pkg::OFS_IRQ_MASK:
          st_next.rdata = {28'h0000000, st_reg.irq_mask};
        fpma_pkg::OFS_SETTING:
          st_next.rdata = {30'h00000000, st_reg.op_mode};
        fpma_pkg::OFS_IP_ADDR:   st_next.rdata = st_reg.ip_addr;
        fpma_pkg::OFS_NET_MASK:  st_next.rdata = st_reg.net_mask;
        fpma_pkg::OFS_GATEWAY:   st_next.rdata = st_reg.gateway;
        fpma_pkg::OFS_ADDR_METH:
          st_next.rdata = {30'h00000000, st_reg.addr_meth};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg              <= '0;
      st_reg.mode         <= fpma_pkg::ST_IDLE;
      st_reg.sup_en       <= fpma_pkg::RST_SUP_EN;
      st_reg.alarm_en     <= fpma_pkg::RST_ALARM_EN;
      st_reg.irq_mask     <= fpma_pkg::RST_IRQ_MASK;
      st_reg.ip_addr      <= fpma_pkg::RST_IP;
      st_reg.net_mask     <= fpma_pkg::RST_IP;
      st_reg.gateway      <= fpma_pkg::RST_IP;
      st_reg.addr_meth    <= fpma_pkg::METH_BOOTP;
      st_reg.op_mode      <= fpma_pkg::OPM_PLAIN;
      st_reg.sel          <= fpma_pkg::SEL_KEEP;
      st_reg.led          <= fpma_pkg::LED_DARK;
      st_reg.disp         <= fpma_pkg::DISP_BLANK;
      st_reg.alarm_closed <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata    = st_reg.rdata;
  assign mode_led     = st_reg.led;
  assign disp_code    = st_reg.disp;
  assign alarm_closed = st_reg.alarm_closed;
  assign op_mode      = st_reg.op_mode;
  assign cfg_commit   = st_reg.commit;
  assign cfg_save_req = st_reg.save_req;
  assign irq          = st_reg.irq;

endmodule : fpma_top

// ===== fpma_panel_model.sv
// Operator push button model with contact chatter
module fpma_panel_model (
  // Clock
  input  wire logic clk,
  // Operator intent and button contact
  input  wire logic press,
  output logic      mode_button
);
  logic       held   = 1'h0;
  logic [1:0] bounce = 2'h0;

  // Contact chatters for a cycle after every change of intent
  always_ff @(posedge clk) begin
    if (press != held) begin
      held   <= press;
      bounce <= 2'h2;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
    end
  end

  // Chatter stays shorter than the debounce window
  assign mode_button = (bounce == 2'h1) ? !held : held;
endmodule : fpma_panel_model

// ===== fpma_properties.sv
// Port checker of the front panel block
module fpma_checker #(
  parameter int HOLD_CYCLES     = 40,
  parameter int DEBOUNCE_CYCLES = 3,
  parameter int FLASH_CYCLES    = 8
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         srst,
  // Supplies, faults and events
  input wire logic                         supply_input_a,
  input wire logic                         supply_input_b,
  input wire logic [fpma_pkg::NUM_ERR-1:1] ext_fault,
  input wire logic                         boot_done,
  input wire logic                         restart_req,
  input wire logic                         mem_present,
  // Panel and configuration
  input wire logic [2:0]                   mode_led,
  input wire logic [2:0]                   disp_code,
  input wire logic                         alarm_closed,
  input wire logic                         cfg_commit,
  input wire logic                         cfg_save_req
);
  localparam int FL2 = 2 * FLASH_CYCLES + 2;
  logic [2:0] pat;

  // ==========================================================================
  // LED pattern of the option on the display
  // ==========================================================================
  always_comb begin
    case (disp_code)
      3'h1:    pat = 3'h4;
      3'h2:    pat = 3'h2;
      3'h3:    pat = 3'h6;
      default: pat = 3'h1;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence in_mode_s;
    disp_code != 3'h0;
  endsequence
  sequence entered_s;
    $rose(disp_code != 3'h0);
  endsequence

  // ==========================================================================
  // Properties
  // ==========================================================================
  closed_a: assert property (
    ext_fault == 7'h00 && supply_input_a == supply_input_b |=> alarm_closed)
    else $error("alarm contact open without a fault");
  commit_a: assert property (
    cfg_commit |=> !cfg_commit && disp_code == 3'h0)
    else $error("commit not a single pulse leaving the mode");
  save_a: assert property (
    restart_req && mem_present |=> cfg_save_req)
    else $error("restart did not save configuration");
  save_cause_a: assert property (
    cfg_save_req |-> $past(restart_req) && $past(mem_present))
    else $error("save request without restart");
  dark_a: assert property (
    disp_code == 3'h0 && $past(disp_code) == 3'h0 |-> mode_led == 3'h0)
    else $error("mode LEDs lit outside selection");
  shown_a: assert property (
    disp_code != 3'h0 && $stable(disp_code) |-> mode_led == 3'h7 ||
    mode_led == pat)
    else $error("mode LEDs show a wrong pattern");
  flash_a: assert property (
    in_mode_s |-> ##[0:FL2] (mode_led == 3'h7 || disp_code == 3'h0))
    else $error("mode LEDs not flashing");
  advance_a: assert property (
    disp_code != 3'h0 && $past(disp_code) != 3'h0 && $changed(disp_code)
    |-> disp_code == ($past(disp_code) == 3'h4 ? 3'h1 : $past(disp_code) + 3'h1))
    else $error("selection did not step to next option");
  enter_a: assert property (
    entered_s |-> $past(boot_done) && disp_code == 3'h1)
    else $error("selection entered wrongly");
endmodule : fpma_checker

bind fpma_top fpma_checker #(
  .HOLD_CYCLES(HOLD_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .FLASH_CYCLES(FLASH_CYCLES)
) chk (
  .clk(clk), .srst(srst), .supply_input_a(supply_input_a),
  .supply_input_b(supply_input_b), .ext_fault(ext_fault),
  .boot_done(boot_done), .restart_req(restart_req),
  .mem_present(mem_present), .mode_led(mode_led), .disp_code(disp_code),
  .alarm_closed(alarm_closed), .cfg_commit(cfg_commit),
  .cfg_save_req(cfg_save_req)
);

// ===== test_front_panel_mode_and_alarm.sv
// Self-checking bench of the front panel block
module test_front_panel_mode_and_alarm;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam logic [1:0] OPS[4]  = '{2'h1, 2'h2, 2'h2, 2'h0};
  localparam logic [2:0] PATS[4] = '{3'h6, 3'h1, 3'h4, 3'h2};
  logic        clk            = 1'h0;
  logic        srst           = 1'h1;
  logic [7:0]  reg_addr       = 8'h00;
  logic [31:0] reg_wdata      = 32'h0;
  logic        reg_wr         = 1'h0;
  logic        reg_rd         = 1'h0;
  logic        supply_input_a = 1'h1;
  logic        supply_input_b = 1'h1;
  logic [7:1]  ext_fault      = 7'h00;
  logic        boot_done      = 1'h0;
  logic        restart_req    = 1'h0;
  logic        mem_present    = 1'h1;
  logic        press          = 1'h0;
  logic        rd_d           = 1'h0;
  logic [15:0] lfsr           = 16'h0019;
  logic        mode_button;
  logic [31:0] reg_rdata;
  logic [2:0]  mode_led;
  logic [2:0]  disp_code;
  logic        alarm_closed;
  logic [1:0]  op_mode;
  logic        cfg_commit;
  logic        cfg_save_req;
  logic        irq;
  logic [7:0]  err_vec;
  logic [31:0] exp_q[$];
  int          err_total      = 0;
  int          total_checks   = 0;

  fpma_top #(.HOLD_CYCLES(40), .DEBOUNCE_CYCLES(3), .FLASH_CYCLES(8)) uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_input_a(supply_input_a), .supply_input_b(supply_input_b),
    .ext_fault(ext_fault), .boot_done(boot_done),
    .restart_req(restart_req), .mem_present(mem_present),
    .mode_button(mode_button), .mode_led(mode_led), .disp_code(disp_code),
    .alarm_closed(alarm_closed), .op_mode(op_mode),
    .cfg_commit(cfg_commit), .cfg_save_req(cfg_save_req), .irq(irq));
  fpma_panel_model btn (.clk(clk), .press(press), .mode_button(mode_button));

  // Clock of 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic summarize;
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'h0;
  endtask : rd

  // Button held for n cycles, then released long enough to settle
  task automatic hold(input int n);
    press <= 1'h1;
    cyc(n);
    press <= 1'h0;
    cyc(12);
  endtask : hold

  task automatic flash(input logic [2:0] p);
    logic a = 1'h0;
    logic b = 1'h0;
    repeat (20) begin
      @(negedge clk);
      a |= (mode_led === 3'h7);
      b |= (mode_led === p);
    end
    check("mode_led", 32'h3, {a, b});
  endtask : flash

  // Long hold until the commit pulse, bounded
  task automatic leave(input logic [1:0] eop);
    int n = 0;
    press <= 1'h1;
    while (cfg_commit !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      summarize();
    end else check("op_mode", eop, op_mode);
    @(posedge clk);
    hold(0);
  endtask : leave

  // Read data checked in the cycle after the read strobe
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) check("reg_rdata", exp_q.pop_front(), reg_rdata);
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    cyc(10);
    srst <= 1'h0;
    rd(fpma_pkg::OFS_CTRL, 32'h1);
    rd(fpma_pkg::OFS_ALARM_EN, 32'h3);
    rd(8'h3C, 32'h0);
    ext_fault <= 7'h01;
    cyc(3);
    check("alarm_closed", 32'h0, alarm_closed);
    ext_fault <= 7'h02;
    cyc(3);
    check("alarm_closed", 32'h1, alarm_closed);
    supply_input_b <= 1'h0;
    cyc(3);
    check("alarm_closed", 32'h0, alarm_closed);
    check("irq", 32'h0, irq);
    wr(fpma_pkg::OFS_IRQ_MASK, 32'hF);
    cyc(2);
    check("irq", 32'h1, irq);
    rd(fpma_pkg::OFS_IRQ_STAT, 32'h9);
    cyc(3);
    check("irq", 32'h0, irq);
    wr(fpma_pkg::OFS_CTRL, 32'h0);
    cyc(3);
    check("alarm_closed", 32'h1, alarm_closed);
    wr(fpma_pkg::OFS_CTRL, 32'h1);
    repeat (12) begin
      lfsr = lfsr_next(lfsr);
      supply_input_b <= lfsr[0];
      ext_fault <= lfsr[7:1];
      err_vec = {lfsr[7:1], ~lfsr[0]};
      wr(fpma_pkg::OFS_ALARM_EN, {24'h0, lfsr[15:8]});
      cyc(3);
      check("alarm_closed", ~|(err_vec & lfsr[15:8]), alarm_closed);
    end
    supply_input_b <= 1'h1;
    ext_fault <= 7'h00;
    for (int m = 1; m >= 0; m--) begin
      mem_present <= m[0];
      restart_req <= 1'h1;
      @(posedge clk);
      restart_req <= 1'h0;
      @(negedge clk);
      check("cfg_save_req", m, cfg_save_req);
      @(posedge clk);
    end
    wr(fpma_pkg::OFS_SETTING, 32'h2);
    rd(fpma_pkg::OFS_SETTING, 32'h2);
    wr(fpma_pkg::OFS_NET_MASK, 32'hFFFF0000);
    wr(fpma_pkg::OFS_GATEWAY, 32'h0A0B0C01);
    wr(fpma_pkg::OFS_IP_ADDR, 32'h0A0B0C0D);
    wr(fpma_pkg::OFS_ADDR_METH, 32'h1);
    hold(60);
    check("disp_code", 32'h0, disp_code);
    boot_done <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      hold(60);
      check("disp_code", 32'h1, disp_code);
      repeat (4) hold(10);
      check("disp_code", 32'h1, disp_code);
      repeat ((i + 2) % 4) hold(10);
      check("disp_code", (i + 2) % 4 + 1, disp_code);
      flash(PATS[i]);
      leave(OPS[i]);
    end
    rd(fpma_pkg::OFS_IP_ADDR, 32'h0);
    rd(fpma_pkg::OFS_ADDR_METH, 32'h0);
    rd(fpma_pkg::OFS_NET_MASK, 32'h0);
    rd(fpma_pkg::OFS_GATEWAY, 32'h0);
    rd(fpma_pkg::OFS_STATUS, 32'hC300);
    cyc(3);
    summarize();
  end
endmodule : test_front_panel_mode_and_alarm
